// ===== wps_sync.sv
// constants package and two-stage synchroniser for the supervisor
package wps_pkg;
   // ****************************************
   // timebase
   // ****************************************
   localparam longint WPS_CLK_HZ = 100_000_000;
   localparam longint WPS_CLK_PER_MS = WPS_CLK_HZ / 1000;
   localparam longint WPS_WDOG_TIMEOUT_MS = 1000;
   localparam longint WPS_SETTLE_MS = 50;
   localparam int WPS_WDOG_CYCLES = int'(WPS_WDOG_TIMEOUT_MS * WPS_CLK_PER_MS);
   localparam int WPS_SETTLE_CYCLES = int'(WPS_SETTLE_MS * WPS_CLK_PER_MS);
   localparam int WPS_CNT_W = 27;
   // ****************************************
   // status word layout
   // ****************************************
   localparam int WPS_STAT_W = 8;
   localparam int WPS_STAT_PF_BIT = 0;
   localparam int WPS_STAT_WD_BIT = 1;
   localparam logic [WPS_STAT_W-1:0] WPS_STAT_RST = 8'h01;
   localparam logic [WPS_CNT_W-1:0] WPS_CNT_ZERO = 27'h0000000;
   localparam logic [WPS_CNT_W-1:0] WPS_CNT_ONE = 27'h0000001;
endpackage : wps_pkg

module wps_sync (
   // clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // level in and out
   input wire logic async_in,
   input wire logic rst_val_in,
   output logic sync_out
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in ^ rst_val_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q ^ rst_val_in;
endmodule : wps_sync

// ===== wps_supervisor.sv
// watchdog and power supervisor top
// Contract
// - reset forced when no kick arrives within the one second window
// - reset on low supply, held until supply good for 50 ms
// - nmi asserted when power fail input drops below threshold
// - ram chip select forced inactive while reset is active
// - power fail output readable in status bit 0
module wps_supervisor
   import wps_pkg::*;
#(
   parameter int WDOG_CYCLES = WPS_WDOG_CYCLES,
   parameter int SETTLE_CYCLES = WPS_SETTLE_CYCLES
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // comparator pins, high means level good or below threshold
   input wire logic supply_ok_in,
   input wire logic power_fail_input_in,
   // host side
   input wire logic kick_in,
   input wire logic ram_cs_n_in,
   // supervisor outputs
   output logic reset_n_out,
   output logic nmi_n_out,
   output logic ram_cs_n_out,
   output logic watchdog_timeout_output_out,
   output logic power_fail_output_n_out,
   output logic [WPS_STAT_W-1:0] status_out
);
   // ****************************************
   // input synchronisers
   // ****************************************
   logic supply_s;
   logic pf_s;
   logic kick_s;
   logic kick_prev_q;
   logic kick_pulse;

   wps_sync u_sync_supply (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .async_in(supply_ok_in),
      .rst_val_in(1'b0),
      .sync_out(supply_s)
   );

   wps_sync u_sync_pf (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .async_in(power_fail_input_in),
      .rst_val_in(1'b0),
      .sync_out(pf_s)
   );

   wps_sync u_sync_kick (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .async_in(kick_in),
      .rst_val_in(1'b0),
      .sync_out(kick_s)
   );

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         kick_prev_q <= 1'b0;
      end else begin
         kick_prev_q <= kick_s;
      end
   end

   assign kick_pulse = kick_s & ~kick_prev_q;

   // ****************************************
   // watchdog counter
   // ****************************************
   localparam logic [WPS_CNT_W-1:0] WD_LAST = WPS_CNT_W'(WDOG_CYCLES - 1);
   localparam logic [WPS_CNT_W-1:0] SETTLE_LOAD = WPS_CNT_W'(SETTLE_CYCLES);

   function automatic logic [WPS_CNT_W-1:0] cnt_inc(input logic [WPS_CNT_W-1:0] v);
      cnt_inc = v + WPS_CNT_ONE;
   endfunction : cnt_inc

   logic [WPS_CNT_W-1:0] wd_cnt_q;
   logic wd_fire;
   logic [WPS_CNT_W-1:0] hold_cnt_q;
   logic reset_d;
   logic reset_n_q;
   logic rst_hold;

   assign wd_fire = reset_n_q && !kick_pulse && (wd_cnt_q == WD_LAST);

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wd_cnt_q <= WPS_CNT_ZERO;
      end else if (!reset_n_q || kick_pulse || wd_fire) begin
         wd_cnt_q <= WPS_CNT_ZERO;
      end else begin
         wd_cnt_q <= cnt_inc(wd_cnt_q);
      end
   end

   // ****************************************
   // reset hold after dip or timeout
   // ****************************************
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hold_cnt_q <= SETTLE_LOAD;
      end else if (!supply_s || wd_fire) begin
         hold_cnt_q <= SETTLE_LOAD;
      end else if (hold_cnt_q != WPS_CNT_ZERO) begin
         hold_cnt_q <= hold_cnt_q - WPS_CNT_ONE;
      end
   end

   // release only after the last settle cycle has elapsed
   assign reset_d = !supply_s || wd_fire || (hold_cnt_q > WPS_CNT_ONE) ||
                    (hold_cnt_q == WPS_CNT_ONE && !reset_n_q) ? 1'b1 : 1'b0;
   assign rst_hold = reset_d || (hold_cnt_q != WPS_CNT_ZERO);

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reset_n_q <= 1'b0;
         ram_cs_n_out <= 1'b1;
      end else begin
         reset_n_q <= !rst_hold;
         ram_cs_n_out <= rst_hold ? 1'b1 : ram_cs_n_in;
      end
   end

   assign reset_n_out = reset_n_q;

   // ****************************************
   // timeout flag, nmi and status
   // ****************************************
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         watchdog_timeout_output_out <= 1'b0;
      end else if (wd_fire) begin
         watchdog_timeout_output_out <= 1'b1;
      end else if (kick_pulse) begin
         watchdog_timeout_output_out <= 1'b0;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         nmi_n_out <= 1'b1;
         power_fail_output_n_out <= 1'b1;
      end else begin
         nmi_n_out <= !pf_s;
         power_fail_output_n_out <= !pf_s;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         status_out <= WPS_STAT_RST;
      end else begin
         status_out <= '0;
         status_out[WPS_STAT_PF_BIT] <= !pf_s;
         status_out[WPS_STAT_WD_BIT] <= wd_fire ||
            (watchdog_timeout_output_out && !kick_pulse);
      end
   end

   // ****************************************
   // checks
   // ****************************************
   logic [WPS_CNT_W-1:0] good_run_q;

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         good_run_q <= WPS_CNT_ZERO;
      end else if (!supply_s) begin
         good_run_q <= WPS_CNT_ZERO;
      end else if (good_run_q != {WPS_CNT_W{1'b1}}) begin
         good_run_q <= cnt_inc(good_run_q);
      end
   end

   a_wd_fires: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (reset_n_out && !kick_pulse && wd_cnt_q == WD_LAST) |=> !reset_n_out)
      else $error("watchdog expiry did not assert reset");

   a_wd_flag_set: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      wd_fire |=> watchdog_timeout_output_out && status_out[WPS_STAT_WD_BIT])
      else $error("timeout flag not shown after expiry");

   a_supply_reset: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      !supply_s |=> !reset_n_out)
      else $error("low supply did not assert reset");

   a_settle_hold: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      $rose(reset_n_out) |-> good_run_q >= WPS_CNT_W'(SETTLE_CYCLES))
      else $error("reset released before settle time");

   a_nmi_follow: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      pf_s |=> !nmi_n_out ##0 !power_fail_output_n_out)
      else $error("nmi not asserted on power fail");

   a_cs_gated: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      !reset_n_out |-> ram_cs_n_out)
      else $error("ram select active during reset");

   a_status_pf: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      pf_s |=> !status_out[WPS_STAT_PF_BIT])
      else $error("status bit 0 does not show power fail");

   a_kick_restart: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      kick_pulse |=> wd_cnt_q == WPS_CNT_ZERO ##1 wd_cnt_q <= WPS_CNT_ONE)
      else $error("kick did not restart the count");

   a_wd_bound: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      wd_cnt_q <= WD_LAST)
      else $error("watchdog count passed its last value");

   a_hold_reset: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      hold_cnt_q != WPS_CNT_ZERO |-> !reset_n_out)
      else $error("reset released while settle count runs");

   a_nmi_release: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      !pf_s |=> nmi_n_out && power_fail_output_n_out)
      else $error("nmi held without power fail");
endmodule : wps_supervisor

// ===== wps_host.sv
// host processor model: periodic kicker, start-up fault check, ram select traffic
module wps_host
   import wps_pkg::*;
#(
   parameter int PERIOD = 100
) (
   // clock and system reset from the supervisor
   input wire logic clock_in,
   input wire logic sys_reset_n_in,
   // control and status
   input wire logic kick_en_in,
   input wire logic [WPS_STAT_W-1:0] status_in,
   // host outputs
   output logic kick_out,
   output logic ram_cs_n_out,
   output logic fault_seen_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q;
   logic run_q;
   initial begin
      kick_out = 1'b0;
      ram_cs_n_out = 1'b1;
      fault_seen_out = 1'b0;
      cnt_q = 0;
      run_q = 1'b0;
   end
   // ram select toggles always, also while held in reset
   always @(posedge clock_in) begin
      ram_cs_n_out <= ~ram_cs_n_out;
      if (!sys_reset_n_in) begin
         run_q <= 1'b0;
         cnt_q <= 0;
         kick_out <= 1'b0;
      end else if (!run_q) begin
         run_q <= 1'b1;
         fault_seen_out <= status_in[WPS_STAT_WD_BIT];
         kick_out <= 1'b1;
      end else begin
         cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
         kick_out <= kick_en_in && (cnt_q < 4);
      end
   end
endmodule : wps_host

// ===== wps_supervisor_tb_top.sv
// self-checking testbench for the watchdog and power supervisor
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("unexpected at %0t: %s", $time, m); end end
module wps_supervisor_tb_top
   import wps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = 200;
   localparam int S = 50;
   localparam int P = 100;
   logic clock_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic supply_ok_in = 1'b1;
   logic pf_in = 1'b0;
   logic kick_en = 1'b0;
   logic kick, ram_cs_n_in, fault_seen, rst_n, nmi_n, ram_cs_n, watchdog_timeout_output, pf_n, rp, prev_rst;
   logic [WPS_STAT_W-1:0] status;
   int err_count = 0;
   int checked = 0;
   int n;
   always #5 clock_in = ~clock_in;
   wps_supervisor #(.WDOG_CYCLES(W), .SETTLE_CYCLES(S)) DUT (.clock_in(clock_in),
      .reset_n_in(reset_n_in), .supply_ok_in(supply_ok_in), .power_fail_input_in(pf_in),
      .kick_in(kick), .ram_cs_n_in(ram_cs_n_in), .reset_n_out(rst_n), .nmi_n_out(nmi_n),
      .ram_cs_n_out(ram_cs_n), .watchdog_timeout_output_out(watchdog_timeout_output),
      .power_fail_output_n_out(pf_n), .status_out(status));
   wps_host #(.PERIOD(P)) host (.clock_in(clock_in), .sys_reset_n_in(rst_n),
      .kick_en_in(kick_en), .status_in(status), .kick_out(kick),
      .ram_cs_n_out(ram_cs_n_in), .fault_seen_out(fault_seen));
   // ****************************************
   // ram select monitor
   // ****************************************
   always @(negedge clock_in) rp = ram_cs_n_in;
   always @(posedge clock_in) begin
      #1;
      if (rst_n === 1'b0) `CHK(ram_cs_n, 1'b1, "ram select not forced")
      else if (prev_rst === 1'b1) `CHK(ram_cs_n, rp, "ram select not passed")
      prev_rst = rst_n;
   end
   // ****************************************
   // helpers and scenarios
   // ****************************************
   task automatic cyc(input int k);
      repeat (k) @(posedge clock_in);
      #1;
   endtask : cyc
   task automatic wait_rst(input logic lvl, input int max, output int cnt);
      cnt = 0;
      while (rst_n !== lvl && cnt < max) begin
         cyc(1);
         cnt++;
      end
   endtask : wait_rst
   task automatic t_kick;
      @(posedge clock_in);
      kick_en <= 1'b1;
      wait_rst(1'b0, 3 * W, n);
      `CHK(n, 3 * W, "reset despite kicks")
      `CHK(watchdog_timeout_output, 1'b0, "timeout despite kicks")
   endtask : t_kick
   task automatic t_timeout;
      @(posedge clock_in);
      kick_en <= 1'b0;
      wait_rst(1'b0, W + P + 20, n);
      `CHK(n >= W - P && n <= W + 10, 1'b1, "timeout moment")
      `CHK(watchdog_timeout_output, 1'b1, "timeout output")
      `CHK(status[WPS_STAT_WD_BIT], 1'b1, "timeout status")
      wait_rst(1'b1, S + 20, n);
      `CHK(n >= S && n <= S + 10, 1'b1, "hold after timeout")
      @(posedge clock_in);
      kick_en <= 1'b1;
      cyc(10);
      `CHK(fault_seen, 1'b1, "host saw no fault")
      `CHK(watchdog_timeout_output, 1'b0, "timeout output not cleared")
   endtask : t_timeout
   task automatic t_pf;
      @(posedge clock_in);
      pf_in <= 1'b1;
      cyc(4);
      `CHK(nmi_n, 1'b0, "nmi")
      `CHK(pf_n, 1'b0, "power fail output")
      `CHK(status[WPS_STAT_PF_BIT], 1'b0, "power fail status")
      wait_rst(1'b0, 3 * W, n);
      `CHK(n, 3 * W, "reset during power fail")
      @(posedge clock_in);
      pf_in <= 1'b0;
      cyc(4);
      `CHK(nmi_n, 1'b1, "nmi release")
      `CHK(pf_n, 1'b1, "power fail output release")
      `CHK(status[WPS_STAT_PF_BIT], 1'b1, "status release")
   endtask : t_pf
   task automatic t_supply;
      @(posedge clock_in);
      supply_ok_in <= 1'b0;
      cyc(4);
      `CHK(rst_n, 1'b0, "no reset on low supply")
      @(posedge clock_in);
      supply_ok_in <= 1'b1;
      cyc(S / 2);
      @(posedge clock_in);
      supply_ok_in <= 1'b0;
      cyc(1);
      @(posedge clock_in);
      supply_ok_in <= 1'b1;
      wait_rst(1'b1, S + 20, n);
      `CHK(n >= S && n <= S + 10, 1'b1, "settle after dip")
      cyc(10);
      `CHK(fault_seen, 1'b0, "false fault")
   endtask : t_supply
   task automatic results;
      if (err_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      repeat (4) @(posedge clock_in);
      reset_n_in <= 1'b1;
      cyc(0);
      `CHK(status, WPS_STAT_RST, "status in reset")
      wait_rst(1'b1, S + 20, n);
      `CHK(n >= S && n <= S + 10, 1'b1, "settle after reset")
      t_kick();
      t_timeout();
      t_pf();
      t_supply();
      results();
   end
   initial begin
      repeat (20000) @(posedge clock_in);
      err_count++;
      results();
   end
endmodule : wps_supervisor_tb_top
